// *** dsig_pkg.sv ***
// Purpose: Shared constants for the debug security identifier gate
// Assumes: Byte-serial identifier delivery from the emulator link
// Notes: Flash image is presented as a flat 80-bit vector, byte 0 at bit 0
package dsig_pkg;
  localparam int ID_BYTES = 10;
  localparam logic [27:0] ID_FIRST_ADDR = 28'h0000070;
  localparam logic [27:0] ID_LAST_ADDR = 28'h0000079;
  localparam logic [79:0] ID_BLANK_VALUE = 80'hFFFF_FFFF_FFFF_FFFF_FFFF;
  localparam int USE_EN_BYTE = 9;
  localparam int USE_EN_BIT = 7;
  localparam logic [27:0] VEC_CSI0 = 28'h0000290;
  localparam logic [27:0] VEC_CSI3 = 28'h00002F0;
  localparam logic [27:0] VEC_UART0 = 28'h0000310;
  localparam logic [1:0] CH_CSI0 = 2'h0;
  localparam logic [1:0] CH_CSI3 = 2'h1;
  localparam logic [1:0] CH_UART0 = 2'h2;
  typedef enum logic [1:0] {DSIG_LOCKED, DSIG_OPEN, DSIG_DENIED} dsig_state_e;
endpackage : dsig_pkg

// *** dsig_link_if.sv ***
// Purpose: Carries a finished identifier from the link domain to the core
// Assumes: Toggle-handshake crossing
// Notes: Word is held from one toggle until the next; no acknowledge comes back
`timescale 1ns/1ps
interface dsig_link_if;
  logic [79:0] id_word;
  logic id_tgl;
  modport src (output id_word, output id_tgl);
  modport dst (input id_word, input id_tgl);
endinterface : dsig_link_if

// *** dsig_link_rx.sv ***
// Purpose: Collects identifier bytes on the emulator link clock
// Assumes: One byte per cycle of link_byte_vld, first byte for address 0x70
// Notes: Ten bytes complete one identifier; a frame end resets the count
`timescale 1ns/1ps
module dsig_link_rx (
  // Link clock domain
  input wire logic link_clk,
  input wire logic link_rst,
  // Link data
  input wire logic link_frame,
  input wire logic link_byte_vld,
  input wire logic [7:0] link_byte,
  // Toward core
  dsig_link_if.src lnk
);
  import dsig_pkg::*;

  logic [79:0] shift_ff;
  logic [3:0] cnt_ff;
  logic tgl_ff;
  logic [79:0] hold_ff;

  // Byte gathering, byte 0 lands at bit 0
  always_ff @(posedge link_clk) begin
    if (link_rst || !link_frame) begin
      cnt_ff <= 4'h0;
      shift_ff <= 80'h0;
    end else if (link_byte_vld) begin
      shift_ff <= {link_byte, shift_ff[79:8]};
      cnt_ff <= (cnt_ff == 4'(ID_BYTES - 1)) ? 4'h0 : cnt_ff + 4'h1;
    end
  end

  // Event toggle when the tenth byte arrives
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      tgl_ff <= 1'b0;
    end else if (link_frame && link_byte_vld && cnt_ff == 4'(ID_BYTES - 1)) begin
      tgl_ff <= ~tgl_ff;
    end
  end

  // Finished word kept steady while the toggle crosses to the core
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      hold_ff <= 80'h0;
    end else if (link_frame && link_byte_vld && cnt_ff == 4'(ID_BYTES - 1)) begin
      hold_ff <= {link_byte, shift_ff[79:8]};
    end
  end

  assign lnk.id_word = hold_ff; // Registered, never the live pins
  assign lnk.id_tgl = tgl_ff;
endmodule : dsig_link_rx

// *** dsig_gate.sv ***
// Purpose: Debug access gate comparing emulator identifier with flash copy
// Assumes: Flash identifier bytes presented as a static vector with a blank flag
// Notes: Identifier word is captured at the link side and held until the next identifier completes
//
// Behaviour
// - Ten flash bytes 0x70..0x79 are the reference
// - Matching identifier with the use flag set unlocks flash read and emulator
// - Bit 7 of byte 0x79 enables emulator
// - Flag zero refuses debug despite match
// - Unprogrammed identifier reads as all ones
// - No forced break while link interrupt masked
// - Vector placed by chosen serial channel
`timescale 1ns/1ps
module dsig_gate (
  // System clock and control
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Flash identifier image
  input wire logic [79:0] flash_id,
  input wire logic flash_id_blank,
  // Debug configuration
  input wire logic [1:0] link_channel,
  input wire logic link_irq_mask,
  input wire logic break_req,
  // Emulator link
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic link_frame,
  input wire logic link_byte_vld,
  input wire logic [7:0] link_byte,
  // Results
  output logic flash_read_en,
  output logic debug_en,
  output logic id_mismatch,
  output logic use_denied,
  output logic force_break,
  output logic [27:0] dbg_vector
);
  import dsig_pkg::*;

  dsig_link_if lnk ();
  dsig_state_e state_ff;
  logic tgl_s1_ff;
  logic tgl_s2_ff;
  logic tgl_s3_ff;
  logic mask_s1_ff;
  logic mask_s2_ff;
  logic brk_s1_ff;
  logic brk_s2_ff;
  logic [79:0] word_ff;
  logic word_vld_ff;
  logic [79:0] ref_id;
  logic use_en;
  logic id_equal;

  // ----------------------------------------------------------------
  // Link side collector
  // ----------------------------------------------------------------
  dsig_link_rx u_rx (
    .link_clk(link_clk),
    .link_rst(link_rst),
    .link_frame(link_frame),
    .link_byte_vld(link_byte_vld),
    .link_byte(link_byte),
    .lnk(lnk)
  );

  // ----------------------------------------------------------------
  // Crossing and input synchronisers
  // ----------------------------------------------------------------
  // Toggle synchroniser, third stage for edge detect
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tgl_s1_ff <= 1'b0;
      tgl_s2_ff <= 1'b0;
      tgl_s3_ff <= 1'b0;
    end else if (clk_en) begin
      tgl_s1_ff <= lnk.id_tgl;
      tgl_s2_ff <= tgl_s1_ff;
      tgl_s3_ff <= tgl_s2_ff;
    end
  end

  // Pin-level synchronisers for mask and break request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_s1_ff <= 1'b1;
      mask_s2_ff <= 1'b1;
      brk_s1_ff <= 1'b0;
      brk_s2_ff <= 1'b0;
    end else if (clk_en) begin
      mask_s1_ff <= link_irq_mask;
      mask_s2_ff <= mask_s1_ff;
      brk_s1_ff <= break_req;
      brk_s2_ff <= brk_s1_ff;
    end
  end

  // Word capture once the toggle edge is seen
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      word_ff <= 80'h0;
      word_vld_ff <= 1'b0;
    end else if (clk_en) begin
      word_vld_ff <= tgl_s2_ff ^ tgl_s3_ff;
      if (tgl_s2_ff ^ tgl_s3_ff) begin
        word_ff <= lnk.id_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reference and comparison
  // ----------------------------------------------------------------
  // Blank flash behaves as all ones
  assign ref_id = flash_id_blank ? ID_BLANK_VALUE : flash_id;
  assign use_en = ref_id[USE_EN_BYTE * 8 + USE_EN_BIT];
  assign id_equal = (word_ff == ref_id);

  // ----------------------------------------------------------------
  // Lock state
  // ----------------------------------------------------------------
  // Locked at reset; each new identifier re-judged until the gate opens, which then holds
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= DSIG_LOCKED;
    end else if (clk_en && word_vld_ff) begin
      case (state_ff)
        DSIG_LOCKED, DSIG_DENIED: begin
          if (id_equal && use_en) begin
            state_ff <= DSIG_OPEN;
          end else if (id_equal) begin
            state_ff <= DSIG_DENIED;
          end else begin
            state_ff <= DSIG_LOCKED;
          end
        end
        DSIG_OPEN: begin
          state_ff <= DSIG_OPEN;
        end
        default: begin
          state_ff <= DSIG_LOCKED;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Grant, status and break outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flash_read_en <= 1'b0;
      debug_en <= 1'b0;
      id_mismatch <= 1'b0;
      use_denied <= 1'b0;
      force_break <= 1'b0;
    end else if (clk_en) begin
      flash_read_en <= (state_ff == DSIG_OPEN);
      debug_en <= (state_ff == DSIG_OPEN) && use_en;
      use_denied <= (state_ff == DSIG_DENIED);
      if (word_vld_ff) begin
        id_mismatch <= !id_equal;
      end
      force_break <= brk_s2_ff && !mask_s2_ff && (state_ff == DSIG_OPEN);
    end
  end

  // Vector selection by link channel
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dbg_vector <= VEC_CSI0;
    end else if (clk_en) begin
      case (link_channel)
        CH_CSI3: dbg_vector <= VEC_CSI3;
        CH_UART0: dbg_vector <= VEC_UART0;
        default: dbg_vector <= VEC_CSI0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_match_ok;
    word_vld_ff && clk_en && id_equal && use_en && state_ff != DSIG_OPEN;
  endsequence

  a_locked_reset: assert property (@(posedge ref_clk)
    $fell(rst) |-> !flash_read_en && !debug_en)
    else $error("outputs not locked after reset");
  a_unlock_match: assert property (@(posedge ref_clk) disable iff (rst)
    s_match_ok ##1 clk_en |-> ##1 flash_read_en)
    else $error("matching id did not unlock");
  a_flag_denies: assert property (@(posedge ref_clk) disable iff (rst)
    debug_en |-> use_en)
    else $error("debug granted with use flag clear");
  a_blank_ones: assert property (@(posedge ref_clk) disable iff (rst)
    word_vld_ff && clk_en && flash_id_blank && word_ff == ID_BLANK_VALUE
    |=> state_ff == DSIG_OPEN)
    else $error("blank id not all ones");
  a_flag_bit: assert property (@(posedge ref_clk) disable iff (rst)
    word_vld_ff && clk_en && word_ff == ref_id && !ref_id[79] && state_ff != DSIG_OPEN
    |=> state_ff == DSIG_DENIED)
    else $error("use flag taken from wrong bit");
  a_mask_break: assert property (@(posedge ref_clk) disable iff (rst)
    force_break |-> !$past(mask_s2_ff))
    else $error("break while link interrupt masked");
  a_vector_uart: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && link_channel == CH_UART0 |=> dbg_vector == VEC_UART0)
    else $error("uart vector wrong");
  a_mismatch_lock: assert property (@(posedge ref_clk) disable iff (rst)
    word_vld_ff && clk_en && !id_equal && state_ff == DSIG_LOCKED |=> state_ff == DSIG_LOCKED)
    else $error("mismatch left gate unlocked");
  a_ref_span: assert property (@(posedge ref_clk) disable iff (rst)
    word_vld_ff && clk_en && !flash_id_blank && word_ff != flash_id |=> id_mismatch)
    else $error("reference not flash id");
endmodule : dsig_gate

// *** dsig_emu_model.sv ***
// Purpose: Emulator side of the identifier link
// Assumes: Link clock runs only during link reset and for one cycle after it, inside frames and for one cycle after each frame
// Notes: Last byte held for eight link cycles after the last strobe, until the frame ends
`timescale 1ns/1ps
module dsig_emu_model (
  // Link outputs
  output logic link_clk,
  output logic link_rst,
  output logic link_frame,
  output logic link_byte_vld,
  output logic [7:0] link_byte
);
  // Idle levels, clock stopped
  initial begin
    link_clk = 1'b0;
    link_rst = 1'b1;
    link_frame = 1'b0;
    link_byte_vld = 1'b0;
    link_byte = 8'h00;
  end
  // One 15 ns link cycle
  task automatic tick();
    #7.5 link_clk = 1'b1;
    #7.5 link_clk = 1'b0;
  endtask : tick
  // Link reset with the clock running
  task automatic do_reset();
    link_rst = 1'b1;
    repeat (3) tick();
    link_rst = 1'b0;
    tick();
  endtask : do_reset
  // Bytes lowest address first, a short count cuts the frame
  task automatic send_id(input logic [79:0] id, input int nbytes);
    link_frame = 1'b1;
    for (int i = 0; i < nbytes; i++) begin
      link_byte = id[8*i +: 8];
      link_byte_vld = 1'b1;
      tick();
    end
    link_byte_vld = 1'b0;
    repeat (8) tick();
    link_frame = 1'b0;
    link_byte = ~link_byte; // Released line stops showing last byte
    tick();
  endtask : send_id
endmodule : dsig_emu_model

// *** debug_security_id_gate_tb_top.sv ***
// Purpose: Self-checking bench for the debug identifier gate
// Assumes: Emulator model drives the link, bench the rest
// Notes: Each row starts from reset since an open gate stays open
`timescale 1ns/1ps
module debug_security_id_gate_tb_top;
  import dsig_pkg::*;
  typedef struct {
    logic [79:0] flash;
    logic blank;
    logic [1:0] chan;
    logic [79:0] sent;
  } dsig_row_s;
  localparam logic [79:0] ID_A = 80'h8123_4567_89AB_CDEF_0102;
  localparam logic [79:0] ID_B = 80'h7123_4567_89AB_CDEF_0102;
  localparam logic [79:0] ID_A0 = ID_A ^ 80'h1;
  localparam logic [79:0] ID_A9 = ID_A ^ (80'h1 << 72);
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [79:0] flash_id = 80'h0;
  logic flash_id_blank = 1'b0;
  logic [1:0] link_channel = 2'h0;
  logic link_irq_mask = 1'b0;
  logic break_req = 1'b0;
  logic link_clk, link_rst, link_frame, link_byte_vld;
  logic [7:0] link_byte;
  logic flash_read_en, debug_en, id_mismatch, use_denied, force_break;
  logic [27:0] dbg_vector;
  int err_count = 0;
  int checked = 0;
  dsig_row_s rows [6] = '{'{ID_A, 1'b0, CH_CSI0, ID_A}, '{ID_A, 1'b0, CH_CSI3, ID_A0},
    '{ID_A, 1'b0, CH_UART0, ID_A9}, '{ID_B, 1'b0, CH_CSI0, ID_B},
    '{ID_A, 1'b1, 2'h3, ID_BLANK_VALUE}, '{ID_A, 1'b1, CH_CSI3, ID_A}};
  // System clock
  always #5 ref_clk = ~ref_clk;
  dsig_emu_model i_emu (.link_clk(link_clk), .link_rst(link_rst), .link_frame(link_frame),
    .link_byte_vld(link_byte_vld), .link_byte(link_byte));
  dsig_gate i_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .flash_id(flash_id),
    .flash_id_blank(flash_id_blank), .link_channel(link_channel),
    .link_irq_mask(link_irq_mask), .break_req(break_req), .link_clk(link_clk),
    .link_rst(link_rst), .link_frame(link_frame), .link_byte_vld(link_byte_vld),
    .link_byte(link_byte), .flash_read_en(flash_read_en), .debug_en(debug_en),
    .id_mismatch(id_mismatch), .use_denied(use_denied), .force_break(force_break),
    .dbg_vector(dbg_vector));
  // Compare one result
  task automatic check(input string name, input logic [27:0] exp, input logic [27:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check
  // Compare every output
  task automatic check_all(input logic op, mis, dny, brk, input logic [27:0] vec);
    check("flash_read_en", 28'(op), 28'(flash_read_en));
    check("debug_en", 28'(op), 28'(debug_en));
    check("id_mismatch", 28'(mis), 28'(id_mismatch));
    check("use_denied", 28'(dny), 28'(use_denied));
    check("force_break", 28'(brk), 28'(force_break));
    check("dbg_vector", vec, dbg_vector);
  endtask : check_all
  // Link reset first, then core held 6 cycles
  task automatic do_reset();
    i_emu.do_reset();
    @(negedge ref_clk) rst = 1'b1;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
  endtask : do_reset
  // Send an identifier and let it settle
  task automatic send(input logic [79:0] id);
    i_emu.send_id(id, 10);
    repeat (12) @(negedge ref_clk);
  endtask : send
  // Verdict
  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  // Row table, then awkward cases
  initial begin
    logic [79:0] ref_id;
    logic hit;
    do_reset();
    check_all(1'b0, 1'b0, 1'b0, 1'b0, VEC_CSI0);
    foreach (rows[i]) begin
      flash_id = rows[i].flash;
      flash_id_blank = rows[i].blank;
      link_channel = rows[i].chan;
      do_reset();
      ref_id = rows[i].blank ? ID_BLANK_VALUE : rows[i].flash;
      hit = (rows[i].sent === ref_id);
      send(rows[i].sent);
      check_all(hit & ref_id[79], !hit, hit & !ref_id[79], 1'b0,
        rows[i].chan == CH_CSI3 ? VEC_CSI3 : rows[i].chan == CH_UART0 ? VEC_UART0 : VEC_CSI0);
    end
    flash_id = ID_A;
    flash_id_blank = 1'b0;
    link_channel = CH_UART0;
    do_reset();
    break_req = 1'b1;
    send(ID_B);
    check_all(1'b0, 1'b1, 1'b0, 1'b0, VEC_UART0);
    send(ID_A);
    check_all(1'b1, 1'b0, 1'b0, 1'b1, VEC_UART0);
    link_irq_mask = 1'b1;
    repeat (6) @(negedge ref_clk);
    check_all(1'b1, 1'b0, 1'b0, 1'b0, VEC_UART0);
    send(ID_B);
    check_all(1'b1, 1'b1, 1'b0, 1'b0, VEC_UART0);
    // Cut frame must not count toward the next identifier
    break_req = 1'b0;
    link_irq_mask = 1'b0;
    link_channel = CH_CSI0;
    do_reset();
    i_emu.send_id(ID_A, 4);
    repeat (12) @(negedge ref_clk);
    check_all(1'b0, 1'b0, 1'b0, 1'b0, VEC_CSI0);
    send(ID_A);
    check_all(1'b1, 1'b0, 1'b0, 1'b0, VEC_CSI0);
    // Clock enable low freezes the gate and the vector
    link_channel = CH_CSI3;
    do_reset();
    clk_en = 1'b0;
    send(ID_A);
    check_all(1'b0, 1'b0, 1'b0, 1'b0, VEC_CSI0);
    clk_en = 1'b1;
    repeat (8) @(negedge ref_clk);
    check_all(1'b1, 1'b0, 1'b0, 1'b0, VEC_CSI3);
    results();
  end
  // Watchdog far beyond the few microseconds the tests need
  initial begin
    #100000;
    err_count++;
    results();
  end
endmodule : debug_security_id_gate_tb_top
